// file: hw/dam_antenna_menu_control.sv
`timescale 1ns/1ps
module dam_antenna_menu_control #(
  parameter int DEBOUNCE_CYCLES = dam_pkg::DEBOUNCE_CYCLES,
  parameter int ROT_STEP_CYCLES = dam_pkg::ROT_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] menu_pot,
  input wire logic action_button,
  input wire logic menu_select_jumper,
  input wire logic gps_rxd,
  input wire logic [8:0] bearing_in,
  input wire logic [3:0] quality_in,
  input wire logic bearing_valid,
  input wire logic signal_present,
  output logic [3:0] antenna_drive_first,
  output logic [3:0] antenna_drive_fifth,
  output logic pc_txd,
  output logic status_green,
  output dam_pkg::dam_display_s display,
  output logic [3:0] menu_active,
  output logic backlight_bright,
  output logic bargraph_external,
  output logic [1:0] setup_active,
  output logic reporting
);
  logic [3:0] pot_s1_reg;
  logic [3:0] pot_s2_reg;
  logic jmp_s1_reg;
  logic jmp_s2_reg;
  logic gps_s1_reg;
  logic gps_s2_reg;
  logic press;
  logic [3:0] menu_sel;
  dam_pkg::dam_setup_s cur_reg;
  dam_pkg::dam_setup_s slot_reg [0:2];
  logic [1:0] slot_idx_reg;
  logic [1:0] slot_next;
  logic fast_reg;
  logic [2:0] test_ant_reg;
  logic [2:0] ant_idx_reg;
  logic [31:0] rot_cnt_reg;
  logic eight_ant;
  logic [8:0] last_raw_reg;
  logic [8:0] corrected;
  dam_pkg::dam_report_e rpt_state_reg;
  logic [3:0] rpt_idx_reg;
  logic [8:0] rpt_bearing_reg;
  logic [3:0] rpt_q_reg;
  logic [3:0] dig_h;
  logic [3:0] dig_t;
  logic [3:0] dig_u;
  logic [8:0] rem_h;
  logic [7:0] rpt_byte;
  logic [15:0] baud_div;
  logic uart_ready;
  logic uart_txd;
  logic uart_valid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pot_s1_reg <= 4'h0;
      pot_s2_reg <= 4'h0;
      jmp_s1_reg <= 1'b0;
      jmp_s2_reg <= 1'b0;
      gps_s1_reg <= 1'b1;
      gps_s2_reg <= 1'b1;
    end else if (ce) begin
      pot_s1_reg <= menu_pot;
      pot_s2_reg <= pot_s1_reg;
      jmp_s1_reg <= menu_select_jumper;
      jmp_s2_reg <= jmp_s1_reg;
      gps_s1_reg <= gps_rxd;
      gps_s2_reg <= gps_s1_reg;
    end
  end

  // Without the jumper only the report menu is reachable
  assign menu_sel = jmp_s2_reg ? pot_s2_reg : dam_pkg::MENU_REPORT;

  dam_debounce #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .raw_in(action_button),
    .press(press)
  );

  assign slot_next = (slot_idx_reg == dam_pkg::SETUP_LAST) ? 2'h0 : slot_idx_reg + 2'h1;

  // Button actions on the live setup; menu 12 saves it and loads the next slot
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_reg <= dam_pkg::SETUP_RESET;
      slot_reg[0] <= dam_pkg::SETUP_RESET;
      slot_reg[1] <= dam_pkg::SETUP_RESET;
      slot_reg[2] <= dam_pkg::SETUP_RESET;
      slot_idx_reg <= 2'h0;
    end else if (ce && press) begin
      case (menu_sel)
        dam_pkg::MENU_INTEG_DEC: begin
          if (cur_reg.integ > dam_pkg::INTEG_MIN) cur_reg.integ <= cur_reg.integ - 8'h1;
        end
        dam_pkg::MENU_INTEG_INC: begin
          if (cur_reg.integ < dam_pkg::INTEG_MAX) cur_reg.integ <= cur_reg.integ + 8'h1;
        end
        dam_pkg::MENU_CAL_AUTO: begin
          cur_reg.cal <= last_raw_reg;
        end
        dam_pkg::MENU_CAL_DEC: begin
          cur_reg.cal <= (cur_reg.cal == 9'h000) ? dam_pkg::DEG_FULL - 9'h1 : cur_reg.cal - 9'h1;
        end
        dam_pkg::MENU_CAL_INC: begin
          cur_reg.cal <= (cur_reg.cal == dam_pkg::DEG_FULL - 9'h1) ? 9'h000 : cur_reg.cal + 9'h1;
        end
        dam_pkg::MENU_MIN_QUAL: begin
          cur_reg.min_q <= (cur_reg.min_q >= dam_pkg::QUAL_MAX) ? dam_pkg::QUAL_MIN
                                                                 : cur_reg.min_q + 4'h1;
        end
        dam_pkg::MENU_BACKLIGHT: begin
          cur_reg.bright <= ~cur_reg.bright;
        end
        dam_pkg::MENU_BAUD: begin
          cur_reg.baud <= dam_pkg::dam_baud_e'(cur_reg.baud + 2'h1);
        end
        dam_pkg::MENU_BARGRAPH: begin
          cur_reg.bar_ext <= ~cur_reg.bar_ext;
        end
        dam_pkg::MENU_SETUP: begin
          slot_reg[slot_idx_reg] <= cur_reg;
          cur_reg <= slot_reg[slot_next];
          slot_idx_reg <= slot_next;
        end
        dam_pkg::MENU_DIRECTION: begin
          cur_reg.ccw <= ~cur_reg.ccw;
        end
        dam_pkg::MENU_SWITCHING: begin
          cur_reg.sw_mode <= (cur_reg.sw_mode == dam_pkg::SW_8_GND) ? dam_pkg::SW_4_POS
                             : dam_pkg::dam_switch_e'(cur_reg.sw_mode + 3'h1);
        end
        default: begin
        end
      endcase
    end
  end

  // Each press in menu zero flips between five-rotation and selected averaging
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fast_reg <= 1'b0;
    end else if (ce && press && menu_sel == dam_pkg::MENU_INTEG_TOGGLE) begin
      fast_reg <= ~fast_reg;
    end
  end

  assign eight_ant = (cur_reg.sw_mode == dam_pkg::SW_8_POS) || (cur_reg.sw_mode == dam_pkg::SW_8_GND);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      test_ant_reg <= 3'h0;
    end else if (ce && press && menu_sel == dam_pkg::MENU_ANT_TEST) begin
      test_ant_reg <= eight_ant ? test_ant_reg + 3'h1 : {1'b0, test_ant_reg[1:0] + 2'h1};
    end
  end

  // One index only, so a single antenna is ever selected; wraps at 4 or 8
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ant_idx_reg <= 3'h0;
      rot_cnt_reg <= 32'h0;
    end else if (ce) begin
      if (menu_sel == dam_pkg::MENU_ANT_TEST) begin
        ant_idx_reg <= test_ant_reg;
        rot_cnt_reg <= 32'h0;
      end else if (rot_cnt_reg == 32'(ROT_STEP_CYCLES - 1)) begin
        rot_cnt_reg <= 32'h0;
        if (eight_ant) begin
          ant_idx_reg <= cur_reg.ccw ? ant_idx_reg - 3'h1 : ant_idx_reg + 3'h1;
        end else begin
          ant_idx_reg <= {1'b0, cur_reg.ccw ? ant_idx_reg[1:0] - 2'h1 : ant_idx_reg[1:0] + 2'h1};
        end
      end else begin
        rot_cnt_reg <= rot_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      antenna_drive_first <= 4'h0;
      antenna_drive_fifth <= 4'hf;
    end else if (ce) begin
      case (cur_reg.sw_mode)
        dam_pkg::SW_4_POS: begin
          antenna_drive_first <= 4'h1 << ant_idx_reg[1:0];
          antenna_drive_fifth <= 4'hf;
        end
        dam_pkg::SW_4_GND: begin
          antenna_drive_first <= 4'h0;
          antenna_drive_fifth <= ~(4'h1 << ant_idx_reg[1:0]);
        end
        dam_pkg::SW_4_DIFF: begin
          antenna_drive_first <= 4'h1 << ant_idx_reg[1:0];
          antenna_drive_fifth <= ~(4'h1 << ant_idx_reg[1:0]);
        end
        dam_pkg::SW_8_POS: begin
          antenna_drive_first <= ant_idx_reg[2] ? 4'h0 : 4'h1 << ant_idx_reg[1:0];
          antenna_drive_fifth <= ant_idx_reg[2] ? 4'h1 << ant_idx_reg[1:0] : 4'h0;
        end
        default: begin
          antenna_drive_first <= ant_idx_reg[2] ? 4'hf : ~(4'h1 << ant_idx_reg[1:0]);
          antenna_drive_fifth <= ant_idx_reg[2] ? ~(4'h1 << ant_idx_reg[1:0]) : 4'hf;
        end
      endcase
    end
  end

  // Calibration subtracts the forward offset, modulo a full turn
  assign corrected = (bearing_in >= cur_reg.cal) ? bearing_in - cur_reg.cal
                                                 : bearing_in + (dam_pkg::DEG_FULL - cur_reg.cal);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_raw_reg <= 9'h000;
      status_green <= 1'b0;
      display <= '0;
    end else if (ce) begin
      display.returns <= fast_reg ? dam_pkg::INTEG_FAST : cur_reg.integ;
      if (!signal_present) begin
        status_green <= 1'b0;
      end else if (bearing_valid) begin
        last_raw_reg <= bearing_in;
        display.quality <= quality_in;
        status_green <= (quality_in >= cur_reg.min_q);
        if (quality_in >= cur_reg.min_q) begin
          display.bearing <= corrected;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      menu_active <= 4'h0;
      backlight_bright <= 1'b1;
      bargraph_external <= 1'b0;
      setup_active <= 2'h0;
    end else if (ce) begin
      menu_active <= menu_sel;
      backlight_bright <= cur_reg.bright;
      bargraph_external <= cur_reg.bar_ext;
      setup_active <= slot_idx_reg;
    end
  end

  // Report digits come from the frozen display bearing captured at the press
  assign dig_h = (rpt_bearing_reg >= 9'h12c) ? 4'h3 : (rpt_bearing_reg >= 9'h0c8) ? 4'h2 :
                 (rpt_bearing_reg >= 9'h064) ? 4'h1 : 4'h0;
  // Widen before the product so three hundreds does not wrap
  assign rem_h = rpt_bearing_reg - 9'(dig_h) * 9'h064;
  assign dig_t = 4'(rem_h / 9'h00a);
  assign dig_u = 4'(rem_h % 9'h00a);

  always_comb begin
    case (rpt_idx_reg)
      4'h0: rpt_byte = dam_pkg::CH_CR;
      4'h1: rpt_byte = dam_pkg::CH_LF;
      4'h2: rpt_byte = dam_pkg::CH_PCT;
      4'h3: rpt_byte = dam_pkg::CH_ZERO + {4'h0, dig_h};
      4'h4: rpt_byte = dam_pkg::CH_ZERO + {4'h0, dig_t};
      4'h5: rpt_byte = dam_pkg::CH_ZERO + {4'h0, dig_u};
      4'h6: rpt_byte = dam_pkg::CH_SLASH;
      4'h7: rpt_byte = dam_pkg::CH_ZERO + {4'h0, rpt_q_reg};
      4'h8: rpt_byte = dam_pkg::CH_CR;
      default: rpt_byte = dam_pkg::CH_LF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rpt_state_reg <= dam_pkg::RPT_IDLE;
      rpt_idx_reg <= 4'h0;
      rpt_bearing_reg <= 9'h000;
      rpt_q_reg <= 4'h0;
    end else if (ce) begin
      case (rpt_state_reg)
        dam_pkg::RPT_IDLE: begin
          if (press && menu_sel == dam_pkg::MENU_REPORT) begin
            rpt_state_reg <= dam_pkg::RPT_SEND;
            rpt_idx_reg <= 4'h0;
            rpt_bearing_reg <= display.bearing;
            rpt_q_reg <= (display.quality > dam_pkg::QUAL_MAX) ? dam_pkg::QUAL_MAX : display.quality;
          end
        end
        default: begin
          if (uart_ready) begin
            rpt_idx_reg <= rpt_idx_reg + 4'h1;
            if (rpt_idx_reg == dam_pkg::REPORT_LAST) rpt_state_reg <= dam_pkg::RPT_IDLE;
          end
        end
      endcase
    end
  end

  assign uart_valid = (rpt_state_reg == dam_pkg::RPT_SEND);

  always_comb begin
    case (cur_reg.baud)
      dam_pkg::BAUD_2400: baud_div = dam_pkg::BAUD_DIV_2400;
      dam_pkg::BAUD_4800: baud_div = dam_pkg::BAUD_DIV_4800;
      dam_pkg::BAUD_9600: baud_div = dam_pkg::BAUD_DIV_9600;
      default: baud_div = dam_pkg::BAUD_DIV_19200;
    endcase
  end

  dam_uart_tx u_uart (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .divisor(baud_div),
    .data(rpt_byte),
    .valid(uart_valid),
    .ready(uart_ready),
    .txd(uart_txd)
  );

  // GPS is cut mid-character if need be; the report has priority on the line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_txd <= 1'b1;
      reporting <= 1'b0;
    end else if (ce) begin
      reporting <= uart_valid || !uart_ready;
      pc_txd <= (uart_valid || !uart_ready) ? uart_txd : gps_s2_reg;
    end
  end
endmodule

// file: hw/dam_debounce.sv
`timescale 1ns/1ps
module dam_debounce #(
  parameter int STABLE_CYCLES = dam_pkg::DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic raw_in,
  output logic press
);
  logic s1_reg;
  logic s2_reg;
  logic stable_reg;
  logic [31:0] cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end

  // Input must hold its new level for the whole window, so bounce gives one press
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stable_reg <= 1'b0;
      cnt_reg <= 32'h0;
      press <= 1'b0;
    end else if (ce) begin
      press <= 1'b0;
      if (s2_reg == stable_reg) begin
        cnt_reg <= 32'h0;
      end else if (cnt_reg == 32'(STABLE_CYCLES - 1)) begin
        cnt_reg <= 32'h0;
        stable_reg <= s2_reg;
        press <= s2_reg;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end
endmodule

// file: hw/dam_uart_tx.sv
`timescale 1ns/1ps
module dam_uart_tx (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [15:0] divisor,
  input wire logic [7:0] data,
  input wire logic valid,
  output logic ready,
  output logic txd
);
  logic [9:0] shift_reg;
  logic [3:0] bits_reg;
  logic [15:0] baud_reg;

  assign ready = (bits_reg == 4'h0);

  // 8N1 framing, LSB first; divisor is read live, so change baud only while idle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shift_reg <= 10'h3ff;
      bits_reg <= 4'h0;
      baud_reg <= 16'h0;
      txd <= 1'b1;
    end else if (ce) begin
      if (ready) begin
        txd <= 1'b1;
        if (valid) begin
          shift_reg <= {1'b1, data, 1'b0};
          bits_reg <= 4'ha;
          baud_reg <= 16'h0;
        end
      end else begin
        txd <= shift_reg[0];
        if (baud_reg == divisor - 16'h1) begin
          baud_reg <= 16'h0;
          shift_reg <= {1'b1, shift_reg[9:1]};
          bits_reg <= bits_reg - 4'h1;
        end else begin
          baud_reg <= baud_reg + 16'h1;
        end
      end
    end
  end
endmodule

// file: pkg/dam_pkg.sv
// Contract
// - Positive mode drives selected first-group output high
// - Ground mode pulls selected fifth-group output low
// - Differential mode drives n high, n+4 low
// - Five switching configurations are selectable
// - Rotation direction clockwise or counter-clockwise
// - Test menu stops rotation, picks antenna
// - Report baud 2400, 4800, 9600 or 19200
// - Report is CR LF %ddd/q CR LF
// - GPS passes through, cut during reports
// - Returns below quality threshold do not update
// - Green on good signal, red freezes bearing
// - Menu zero press toggles integration off/on
// - Fast integration uses five rotations
// - Menu one press sends one report
// - Menus two/three step integration down/up
// - Menu four calibrates current bearing forward
// - Menus five/six step calibration down/up
// - Jumper removed leaves only report menu
// - Bargraph source external meter or filter
// - Three stored setups, one active
// - Backlight bright or dim
// - Display shows quality, bearing, integration count
// - Potentiometer picks menu, button executes it
package dam_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int ROT_STEP_US = 100;
  localparam int ROT_STEP_CYCLES = CLK_HZ / 1_000_000 * ROT_STEP_US;

  localparam logic [15:0] BAUD_DIV_2400 = 16'(CLK_HZ / 2400);
  localparam logic [15:0] BAUD_DIV_4800 = 16'(CLK_HZ / 4800);
  localparam logic [15:0] BAUD_DIV_9600 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] BAUD_DIV_19200 = 16'(CLK_HZ / 19200);

  localparam logic [3:0] MENU_INTEG_TOGGLE = 4'h0;
  localparam logic [3:0] MENU_REPORT = 4'h1;
  localparam logic [3:0] MENU_INTEG_DEC = 4'h2;
  localparam logic [3:0] MENU_INTEG_INC = 4'h3;
  localparam logic [3:0] MENU_CAL_AUTO = 4'h4;
  localparam logic [3:0] MENU_CAL_DEC = 4'h5;
  localparam logic [3:0] MENU_CAL_INC = 4'h6;
  localparam logic [3:0] MENU_MIN_QUAL = 4'h7;
  localparam logic [3:0] MENU_BACKLIGHT = 4'h8;
  localparam logic [3:0] MENU_BAUD = 4'ha;
  localparam logic [3:0] MENU_BARGRAPH = 4'hb;
  localparam logic [3:0] MENU_SETUP = 4'hc;
  localparam logic [3:0] MENU_DIRECTION = 4'hd;
  localparam logic [3:0] MENU_SWITCHING = 4'he;
  localparam logic [3:0] MENU_ANT_TEST = 4'hf;

  localparam logic [7:0] INTEG_FAST = 8'h05;
  localparam logic [7:0] INTEG_MIN = 8'h01;
  localparam logic [7:0] INTEG_MAX = 8'hff;
  localparam logic [8:0] DEG_FULL = 9'h168;
  localparam logic [3:0] QUAL_MIN = 4'h1;
  localparam logic [3:0] QUAL_MAX = 4'h8;
  localparam logic [1:0] SETUP_LAST = 2'h2;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_SLASH = 8'h2f;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [3:0] REPORT_LAST = 4'h9;

  typedef enum logic [2:0] {
    SW_4_POS = 3'h0,
    SW_4_GND = 3'h1,
    SW_4_DIFF = 3'h2,
    SW_8_POS = 3'h3,
    SW_8_GND = 3'h4
  } dam_switch_e;

  typedef enum logic [1:0] {
    BAUD_2400 = 2'h0,
    BAUD_4800 = 2'h1,
    BAUD_9600 = 2'h2,
    BAUD_19200 = 2'h3
  } dam_baud_e;

  typedef enum logic [0:0] {
    RPT_IDLE = 1'h0,
    RPT_SEND = 1'h1
  } dam_report_e;

  typedef struct packed {
    logic [7:0] integ;
    logic [8:0] cal;
    logic [3:0] min_q;
    dam_baud_e baud;
    logic bar_ext;
    logic ccw;
    dam_switch_e sw_mode;
    logic bright;
  } dam_setup_s;

  localparam dam_setup_s SETUP_RESET = '{integ: 8'h10, cal: 9'h000, min_q: 4'h1, baud: BAUD_4800,
                                         bar_ext: 1'b0, ccw: 1'b0, sw_mode: SW_4_POS, bright: 1'b1};

  typedef struct packed {
    logic [8:0] bearing;
    logic [3:0] quality;
    logic [7:0] returns;
  } dam_display_s;

endpackage

// file: tb/dam_amc_properties.sv
`timescale 1ns/1ps
module dam_amc_properties #(
  parameter int ROT_STEP_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] menu_pot,
  input wire logic menu_select_jumper,
  input wire logic [3:0] quality_in,
  input wire logic bearing_valid,
  input wire logic signal_present,
  input wire logic [3:0] antenna_drive_first,
  input wire logic [3:0] antenna_drive_fifth,
  input wire logic pc_txd,
  input wire logic status_green,
  input wire dam_pkg::dam_display_s display,
  input wire logic [3:0] menu_active,
  input wire logic reporting
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [7:0] ant_reg;
  logic [15:0] gap_reg;
  logic valid_reg;
  logic ant_chg;
  assign ant_chg = {antenna_drive_first, antenna_drive_fifth} != ant_reg;
  always_ff @(posedge ref_clk) begin
    ant_reg <= {antenna_drive_first, antenna_drive_fifth};
  end
  always_ff @(posedge ref_clk) begin
    if (srst || ant_chg) begin
      gap_reg <= 16'h0;
    end else if (gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h1;
    end
  end
  // Only steps between two free-running steps are timed; mode or test presses restart the phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      valid_reg <= 1'b0;
    end else if (ant_chg) begin
      valid_reg <= menu_active < 4'hc && ant_reg != 8'h0f;
    end
  end
  a_reset_state: assert property (disable iff (1'b0) srst |=> antenna_drive_first == 4'h0 &&
    antenna_drive_fifth == 4'hf && pc_txd && !reporting && !status_green) else $error("reset state wrong");
  a_one_antenna: assert property ({antenna_drive_first, antenna_drive_fifth} != 8'h0f |->
    $onehot(antenna_drive_first) || $onehot(~antenna_drive_first) || $onehot(antenna_drive_fifth) ||
    $onehot(~antenna_drive_fifth)) else $error("antenna pattern not single");
  a_step_rate: assert property (ant_chg && valid_reg && menu_active < 4'hc |->
    gap_reg == 16'(ROT_STEP_CYCLES - 1)) else $error("antenna step spacing wrong");
  a_quality_shown: assert property (bearing_valid && signal_present |=>
    display.quality == $past(quality_in)) else $error("quality not shown");
  a_poor_red: assert property (bearing_valid && signal_present && quality_in == 4'h0 |=>
    !status_green) else $error("poor return shows green");
  a_good_green: assert property (bearing_valid && signal_present && quality_in == 4'h8 |=>
    status_green) else $error("good return not green");
  a_no_signal_red: assert property (!signal_present |=> !status_green) else $error("green without signal");
  a_bearing_frozen: assert property (!signal_present |=> $stable(display.bearing))
    else $error("bearing moved without signal");
  a_low_q_frozen: assert property (bearing_valid && quality_in == 4'h0 |=> $stable(display.bearing))
    else $error("bearing moved on poor return");
  a_report_start: assert property ($rose(reporting) |-> ##2 !pc_txd) else $error("report without start bit");
  a_jumper_menu: assert property (!menu_select_jumper [*6] |-> menu_active == 4'h1)
    else $error("jumper removed but menu not report");
  a_menu_follows: assert property ((menu_select_jumper && $stable(menu_select_jumper) &&
    $stable(menu_pot)) [*6] |-> menu_active == menu_pot) else $error("menu does not follow pot");
  c_report: cover property ($rose(reporting));
  c_test_menu: cover property (menu_active == 4'hf && ant_chg);
  c_poor: cover property (bearing_valid && signal_present && quality_in == 4'h0);
endmodule
bind dam_antenna_menu_control dam_amc_properties #(.ROT_STEP_CYCLES(ROT_STEP_CYCLES)) chk_i (
  .ref_clk(ref_clk), .srst(srst), .menu_pot(menu_pot), .menu_select_jumper(menu_select_jumper),
  .quality_in(quality_in), .bearing_valid(bearing_valid), .signal_present(signal_present),
  .antenna_drive_first(antenna_drive_first), .antenna_drive_fifth(antenna_drive_fifth), .pc_txd(pc_txd),
  .status_green(status_green), .display(display), .menu_active(menu_active), .reporting(reporting));

// file: tb/dam_pc_station.sv
`timescale 1ns/1ps
module dam_pc_station #(
  parameter int DIV = 1041
) (
  input wire logic ref_clk,
  input wire logic pc_txd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  // Mid-bit sampling; a bad stop bit drops the byte so the count shows it
  initial begin
    forever begin
      @(negedge pc_txd);
      repeat (DIV / 2) @(posedge ref_clk);
      if (pc_txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(posedge ref_clk);
          sh = {pc_txd, sh[7:1]};
        end
        repeat (DIV) @(posedge ref_clk);
        if (pc_txd === 1'b1) begin
          rx_q.push_back(sh);
        end
      end
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int DEB = 4;
  localparam int ROT = 8;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] pot = 4'h0;
  logic btn = 1'b0;
  logic jmp = 1'b1;
  logic gps = 1'b1;
  logic [8:0] brg = 9'h0;
  logic [3:0] qin = 4'h0;
  logic bv = 1'b0;
  logic sig = 1'b1;
  logic [3:0] a1, a5, mact;
  logic txd, green, bright, barx, rep;
  logic [1:0] setup;
  dam_pkg::dam_display_s disp;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] rows[7] = '{8'h80, 8'hc9, 8'hbd, 8'hca, 8'hc0, 8'hcd, 8'hb9};
  logic [7:0] msg[10] = '{8'h0d, 8'h0a, 8'h25, 8'h33, 8'h32, 8'h39, 8'h2f, 8'h38, 8'h0d, 8'h0a};
  always #25 ref_clk = ~ref_clk;
  dam_antenna_menu_control #(.DEBOUNCE_CYCLES(DEB), .ROT_STEP_CYCLES(ROT)) uut (
    .ref_clk(ref_clk), .srst(srst), .ce(1'b1), .menu_pot(pot), .action_button(btn),
    .menu_select_jumper(jmp), .gps_rxd(gps), .bearing_in(brg), .quality_in(qin), .bearing_valid(bv),
    .signal_present(sig), .antenna_drive_first(a1), .antenna_drive_fifth(a5), .pc_txd(txd),
    .status_green(green), .display(disp), .menu_active(mact), .backlight_bright(bright),
    .bargraph_external(barx), .setup_active(setup), .reporting(rep));
  dam_pc_station #(.DIV(int'(dam_pkg::BAUD_DIV_19200))) pc (.ref_clk(ref_clk), .pc_txd(txd));
  task automatic tally_and_finish();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic press(input logic [3:0] m);
    pot = m;
    tick(6);
    btn = 1'b1;
    tick(2 * DEB + 6);
    btn = 1'b0;
    tick(2 * DEB + 6);
  endtask
  task automatic rc(input logic [8:0] b, input logic [3:0] q, input logic [8:0] eb, input logic g);
    brg = b;
    qin = q;
    bv = 1'b1;
    tick(1);
    bv = 1'b0;
    tick(2);
    chk(32'({disp.bearing, green}), 32'({eb, g}));
  endtask
  task automatic integ(input logic [3:0] m, input logic [7:0] e);
    press(m);
    rc(9'd20, 4'h8, 9'd329, 1'b1);
    chk(32'(disp.returns), 32'(e));
  endtask
  function automatic logic [7:0] pat(input int md, input int i);
    logic [7:0] o;
    o = 8'h1 << i;
    case (md)
      0: pat = {o[3:0], 4'hf};
      1: pat = {4'h0, ~o[3:0]};
      2: pat = {o[3:0], ~o[3:0]};
      3: pat = {o[3:0], o[7:4]};
      default: pat = ~{o[3:0], o[7:4]};
    endcase
  endfunction
  function automatic int find(input int md);
    find = -1;
    for (int j = 0; j < ((md > 2) ? 8 : 4); j++) begin
      if (pat(md, j) === {a1, a5}) begin
        find = j;
      end
    end
  endfunction
  task automatic step(input int md, input int n, input int dir);
    int k1;
    k1 = find(md);
    tick(ROT);
    chk(32'(k1 >= 0), 32'h1);
    chk(32'(find(md)), 32'((k1 + dir) % n));
  endtask
  initial begin
    repeat (150000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    int k;
    tick(20);
    chk(32'({a1, a5, txd, rep, green, bright, barx, setup}), 32'h07c8);
    chk(32'({disp, mact}), 32'h0);
    srst = 1'b0;
    tick(4);
    for (int i = 0; i < 7; i++) begin
      press(rows[i][7:4]);
      chk(32'({bright, barx, setup}), 32'(rows[i][3:0]));
    end
    rc(9'd100, 4'h5, 9'd100, 1'b1);
    rc(9'd200, 4'h0, 9'd100, 1'b0);
    sig = 1'b0;
    rc(9'd300, 4'h8, 9'd100, 1'b0);
    sig = 1'b1;
    repeat (3) press(4'h7);
    rc(9'd50, 4'h3, 9'd100, 1'b0);
    rc(9'd50, 4'h4, 9'd50, 1'b1);
    press(4'h4);
    rc(9'd60, 4'h8, 9'd10, 1'b1);
    press(4'h5);
    rc(9'd60, 4'h8, 9'd11, 1'b1);
    repeat (2) press(4'h6);
    rc(9'd20, 4'h8, 9'd329, 1'b1);
    integ(4'h0, 8'h05);
    integ(4'h0, 8'h10);
    integ(4'h3, 8'h11);
    integ(4'h2, 8'h10);
    integ(4'h2, 8'h0f);
    pot = 4'h9;
    for (int m = 0; m < 5; m++) begin
      tick(ROT);
      step(m, (m > 2) ? 8 : 4, 1);
      press(4'he);
      pot = 4'h9;
    end
    press(4'hd);
    step(0, 4, 3);
    press(4'hd);
    step(0, 4, 1);
    press(4'hf);
    step(0, 4, 0);
    k = find(0);
    press(4'hf);
    chk(32'(find(0)), 32'((k + 1) % 4));
    jmp = 1'b0;
    pot = 4'h5;
    tick(8);
    chk(32'(mact), 32'h1);
    jmp = 1'b1;
    tick(8);
    chk(32'(mact), 32'h5);
    pot = 4'h9;
    gps = 1'b0;
    tick(6);
    chk(32'(txd), 32'h0);
    gps = 1'b1;
    repeat (2) press(4'ha);
    pc.rx_q.delete();
    press(4'h1);
    chk(32'(rep), 32'h1);
    press(4'h1);
    // GPS keeps toggling so any leak into the report corrupts a byte
    for (int c = 0; c < 110000 && rep !== 1'b0; c++) begin
      gps = ~gps;
      tick(1);
    end
    gps = 1'b1;
    tick(2000);
    chk(32'(pc.rx_q.size()), 32'd10);
    for (int i = 0; i < 10 && i < pc.rx_q.size(); i++) begin
      chk(32'(pc.rx_q[i]), 32'(msg[i]));
    end
    tally_and_finish();
  end
endmodule
